/* pss_pkg.sv */
// constants for the phy status and interrupt control register bank
package pss_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int NUM_EVENTS = 7;

    localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
    localparam logic [4:0] ADDR_AN_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_PHY_STATUS = 5'h10;
    localparam logic [4:0] ADDR_INT_CONTROL = 5'h11;
    localparam logic [4:0] ADDR_EVENT_STATUS = 5'h12;

    // consolidated status bit positions
    localparam int ST_PAGE = 8;
    localparam int ST_IRQ = 7;
    localparam int ST_RFAULT = 6;
    localparam int ST_JABBER = 5;
    localparam int ST_ANDONE = 4;
    localparam int ST_LOOP = 3;
    localparam int ST_DUPLEX = 2;
    localparam int ST_SPEED10 = 1;
    localparam int ST_LINK = 0;

    // interrupt control bit positions
    localparam int IC_TEST = 2;
    localparam int IC_GATE = 1;
    localparam int IC_PINOUT = 0;
    localparam int IC_LOW_W = 3;

    // event indices: flags at bit FLAG_BASE+i, enables at bit i
    localparam int EV_RX_HALF = 0;
    localparam int EV_FC_HALF = 1;
    localparam int EV_AN_DONE = 2;
    localparam int EV_DUPLEX = 3;
    localparam int EV_SPEED = 4;
    localparam int EV_LINK = 5;
    localparam int EV_ENERGY = 6;
    localparam int FLAG_BASE = 8;

    localparam logic [15:0] ZERO_WORD = 16'h0000;
endpackage

/* pss_event_latch.sv */
// sticky event flags with their per-event enables
`timescale 1ns/1ps
module pss_event_latch import pss_pkg::*; #(
    parameter int EVENTS = NUM_EVENTS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [EVENTS-1:0] eventPulse,
    input wire logic clearFlags,
    input wire logic enableWrite,
    input wire logic [EVENTS-1:0] enableData,
    output logic [EVENTS-1:0] flags,
    output logic [EVENTS-1:0] enables
);
    generate
        if (EVENTS < 1 || EVENTS > 7) begin : g_bad
            $error("EVENTS must be 1 to 7");
        end
    endgenerate

    typedef struct packed {
        logic [EVENTS-1:0] flags;
        logic [EVENTS-1:0] enables;
    } pss_ev_state_type;

    pss_ev_state_type state_reg, state_next;

    always_comb begin
        state_next = state_reg;
        // set beats clear so an event in the read cycle survives
        state_next.flags = (state_reg.flags & ~{EVENTS{clearFlags}}) | eventPulse;
        if (enableWrite) begin
            state_next.enables = enableData;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flags;
    assign enables = state_reg.enables;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_FLAG_LATCHES: assert property (
        (|eventPulse) |=> ((flags & $past(eventPulse)) == $past(eventPulse)))
        else $error("event flag failed to latch");
    AST_FLAG_CLEARS: assert property (
        (clearFlags && !(|eventPulse)) |=> (flags == '0))
        else $error("event flags not cleared by read");
endmodule

/* pss_irq_pin.sv */
// shared interrupt output / powerdown input pin
`timescale 1ns/1ps
module pss_irq_pin import pss_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic irqPending,
    input wire logic pinIsOutput,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic powerDownReq
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic out;
        logic oe;
        logic [1:0] oeHist;
        logic pdReq;
    } pss_pin_state_type;

    pss_pin_state_type state_reg, state_next;

    always_comb begin
        state_next = state_reg;
        state_next.sync1 = pinIn;
        state_next.sync2 = state_reg.sync1;
        // pin is active low in both roles
        state_next.oe = pinIsOutput;
        state_next.out = ~(irqPending & pinIsOutput);
        // own low drive sits in the synchroniser for a while after the role change
        state_next.oeHist = {state_reg.oeHist[0], state_reg.oe};
        // own drive would read back as powerdown, so mask it in output mode and just after
        state_next.pdReq = ~pinIsOutput & ~state_reg.oe & ~(|state_reg.oeHist)
            & ~state_reg.sync2;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '{sync1: 1'b1, sync2: 1'b1, out: 1'b1, oe: 1'b0,
                oeHist: 2'h0, pdReq: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign pinOut = state_reg.out;
    assign pinOe = state_reg.oe;
    assign powerDownReq = state_reg.pdReq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_PIN_ROLE: assert property (
        !pinIsOutput |=> (!pinOe && pinOut))
        else $error("pin driven while in powerdown input role");
    AST_PIN_IRQ: assert property (
        (pinIsOutput && irqPending) |=> (pinOe && !pinOut))
        else $error("pending interrupt not driven on pin");
    AST_PIN_NO_ECHO: assert property (
        (state_reg.oe || (|state_reg.oeHist)) |=> !powerDownReq)
        else $error("own pin drive seen as powerdown request");
endmodule

/* pss_status_irq_regs.sv */
// consolidated phy status word, interrupt control and event flags
`timescale 1ns/1ps
module pss_status_irq_regs import pss_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regRdEn,
    input wire logic regWrEn,
    input wire logic [DATA_W-1:0] regWrData,
    output logic [DATA_W-1:0] regRdData,
    output logic regRdValid,
    input wire logic pageReceived,
    input wire logic remoteFaultSeen,
    input wire logic jabberDetect,
    input wire logic anComplete,
    input wire logic loopbackOn,
    input wire logic fullDuplex,
    input wire logic speed10,
    input wire logic linkUp,
    input wire logic energyDetect,
    input wire logic falseCarrierHalf,
    input wire logic rxErrorHalf,
    input wire logic irqPinIn,
    output logic irqPinOut,
    output logic irqPinOe,
    output logic powerDownReq
);
    typedef struct packed {
        logic [DATA_W-1:0] rdData;
        logic rdValid;
        logic pageFlag;
        logic remoteFault;
        logic testForce;
        logic eventGate;
        logic pinIsOutput;
        logic [4:0] prevLevel;
        logic [1:0] prevHalf;
    } pss_state_type;

    pss_state_type state_reg, state_next;
    logic [NUM_EVENTS-1:0] eventPulse;
    logic [NUM_EVENTS-1:0] flags;
    logic [NUM_EVENTS-1:0] enables;
    logic [4:0] levelNow;
    logic [1:0] halfNow;
    logic irqPending;
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] controlWord;
    logic [DATA_W-1:0] eventWord;

    function automatic logic hit(input logic strobe, input logic [4:0] addr,
                                 input logic [4:0] target);
        return strobe && (addr == target);
    endfunction

    // level sources come from logic on this clock, so no synchroniser
    assign levelNow = {energyDetect, linkUp, speed10, fullDuplex, anComplete};
    assign halfNow = {falseCarrierHalf, rxErrorHalf};

    always_comb begin
        eventPulse = '0;
        eventPulse[EV_ENERGY] = levelNow[4] ^ state_reg.prevLevel[4];
        eventPulse[EV_LINK] = levelNow[3] ^ state_reg.prevLevel[3];
        eventPulse[EV_SPEED] = levelNow[2] ^ state_reg.prevLevel[2];
        eventPulse[EV_DUPLEX] = levelNow[1] ^ state_reg.prevLevel[1];
        eventPulse[EV_AN_DONE] = levelNow[0] & ~state_reg.prevLevel[0];
        eventPulse[EV_FC_HALF] = halfNow[1] & ~state_reg.prevHalf[1];
        eventPulse[EV_RX_HALF] = halfNow[0] & ~state_reg.prevHalf[0];
    end

    // event read clears the flags, which drops the pending bit unless forced or an enabled event arrives in the read cycle
    assign irqPending = state_reg.testForce
        | (state_reg.eventGate & (|(flags & enables)));

    always_comb begin
        statusWord = ZERO_WORD;
        statusWord[ST_PAGE] = state_reg.pageFlag;
        statusWord[ST_IRQ] = irqPending;
        statusWord[ST_RFAULT] = state_reg.remoteFault;
        statusWord[ST_JABBER] = jabberDetect;
        statusWord[ST_ANDONE] = anComplete;
        statusWord[ST_LOOP] = loopbackOn;
        statusWord[ST_DUPLEX] = fullDuplex;
        statusWord[ST_SPEED10] = speed10;
        statusWord[ST_LINK] = linkUp;
        controlWord = ZERO_WORD;
        controlWord[IC_TEST] = state_reg.testForce;
        controlWord[IC_GATE] = state_reg.eventGate;
        controlWord[IC_PINOUT] = state_reg.pinIsOutput;
        eventWord = ZERO_WORD;
        eventWord[FLAG_BASE +: NUM_EVENTS] = flags;
        eventWord[NUM_EVENTS-1:0] = enables;
    end

    always_comb begin
        state_next = state_reg;
        state_next.prevLevel = levelNow;
        state_next.prevHalf = halfNow;
        state_next.rdValid = regRdEn;
        if (regRdEn) begin
            unique case (regAddr)
                ADDR_PHY_STATUS: state_next.rdData = statusWord;
                ADDR_INT_CONTROL: state_next.rdData = controlWord;
                ADDR_EVENT_STATUS: state_next.rdData = eventWord;
                default: state_next.rdData = ZERO_WORD;
            endcase
        end
        // set beats the clearing read
        state_next.pageFlag = (state_reg.pageFlag
            & ~hit(regRdEn, regAddr, ADDR_AN_EXPANSION)) | pageReceived;
        state_next.remoteFault = (state_reg.remoteFault
            & ~hit(regRdEn, regAddr, ADDR_BASIC_STATUS)) | remoteFaultSeen;
        // upper control bits have no storage, so writes there vanish
        if (hit(regWrEn, regAddr, ADDR_INT_CONTROL)) begin
            state_next.testForce = regWrData[IC_TEST];
            state_next.eventGate = regWrData[IC_GATE];
            state_next.pinIsOutput = regWrData[IC_PINOUT];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    pss_event_latch #(
        .EVENTS(NUM_EVENTS)
    ) u_events (
        .clk(clk),
        .reset_n(reset_n),
        .eventPulse(eventPulse),
        .clearFlags(hit(regRdEn, regAddr, ADDR_EVENT_STATUS)),
        .enableWrite(hit(regWrEn, regAddr, ADDR_EVENT_STATUS)),
        .enableData(regWrData[NUM_EVENTS-1:0]),
        .flags(flags),
        .enables(enables)
    );

    pss_irq_pin u_pin (
        .clk(clk),
        .reset_n(reset_n),
        .irqPending(irqPending),
        .pinIsOutput(state_reg.pinIsOutput),
        .pinIn(irqPinIn),
        .pinOut(irqPinOut),
        .pinOe(irqPinOe),
        .powerDownReq(powerDownReq)
    );

    assign regRdData = state_reg.rdData;
    assign regRdValid = state_reg.rdValid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_PAGE_HOLDS: assert property (
        (state_reg.pageFlag && !(regRdEn && regAddr == ADDR_AN_EXPANSION))
        |=> state_reg.pageFlag)
        else $error("page flag lost without expansion read");
    AST_STATUS_IRQ: assert property (
        (regRdEn && regAddr == ADDR_PHY_STATUS)
        |=> (regRdValid && regRdData[ST_IRQ] == $past(irqPending)))
        else $error("status irq bit does not show pending state");
    AST_FAULT_CLEAR: assert property (
        (regRdEn && regAddr == ADDR_BASIC_STATUS && !remoteFaultSeen)
        |=> !state_reg.remoteFault)
        else $error("remote fault not cleared by basic status read");
    AST_MIRRORS: assert property (
        (regRdEn && regAddr == ADDR_PHY_STATUS)
        |=> (regRdData[ST_JABBER] == $past(jabberDetect)
             && regRdData[ST_LINK] == $past(linkUp)
             && regRdData[ST_SPEED10] == $past(speed10)))
        else $error("mirrored status bits wrong");
    AST_CTRL_RESERVED: assert property (
        (regRdEn && regAddr == ADDR_INT_CONTROL) |=> (regRdData[DATA_W-1:IC_LOW_W] == '0))
        else $error("reserved control bits not zero");
    AST_TEST_FORCE: assert property (
        state_reg.testForce |-> irqPending)
        else $error("test force did not raise interrupt");
    AST_GATE_BLOCKS: assert property (
        (!state_reg.eventGate && !state_reg.testForce) |-> !irqPending)
        else $error("event interrupt passed a closed gate");

    AST_PAGE_SETS: assert property (
        pageReceived
        |=> state_reg.pageFlag)
        else $error("page flag not set by page event");

    AST_PAGE_CLEARS: assert property (
        (hit(regRdEn, regAddr, ADDR_AN_EXPANSION) && !pageReceived)
        |=> !state_reg.pageFlag)
        else $error("page flag survived expansion read");

    AST_PAGE_READ: assert property (
        hit(regRdEn, regAddr, ADDR_PHY_STATUS)
        |=> (regRdData[ST_PAGE] == $past(state_reg.pageFlag)))
        else $error("status page bit wrong");

    AST_FAULT_SETS: assert property (
        remoteFaultSeen
        |=> state_reg.remoteFault)
        else $error("remote fault not latched");

    AST_FAULT_HOLDS: assert property (
        (state_reg.remoteFault && !hit(regRdEn, regAddr, ADDR_BASIC_STATUS))
        |=> state_reg.remoteFault)
        else $error("remote fault lost without basic status read");

    AST_FAULT_READ: assert property (
        hit(regRdEn, regAddr, ADDR_PHY_STATUS)
        |=> (regRdData[ST_RFAULT] == $past(state_reg.remoteFault)))
        else $error("status remote fault bit wrong");

    AST_ANDONE_BIT: assert property (
        hit(regRdEn, regAddr, ADDR_PHY_STATUS)
        |=> (regRdData[ST_ANDONE] == $past(anComplete)))
        else $error("status auto-negotiation bit wrong");

    AST_LOOP_BIT: assert property (
        hit(regRdEn, regAddr, ADDR_PHY_STATUS)
        |=> (regRdData[ST_LOOP] == $past(loopbackOn)))
        else $error("status loopback bit wrong");

    AST_DUPLEX_BIT: assert property (
        hit(regRdEn, regAddr, ADDR_PHY_STATUS)
        |=> (regRdData[ST_DUPLEX] == $past(fullDuplex)))
        else $error("status duplex bit wrong");

    AST_SPEED_BIT: assert property (
        hit(regRdEn, regAddr, ADDR_PHY_STATUS)
        |=> (regRdData[ST_SPEED10] == $past(speed10)))
        else $error("status speed bit wrong");

    AST_LINK_BIT: assert property (
        hit(regRdEn, regAddr, ADDR_PHY_STATUS)
        |=> (regRdData[ST_LINK] == $past(linkUp)))
        else $error("status link bit wrong");

    AST_TEST_WRITE: assert property (
        hit(regWrEn, regAddr, ADDR_INT_CONTROL)
        |=> (state_reg.testForce == $past(regWrData[IC_TEST])))
        else $error("test force bit not written");

    AST_GATE_WRITE: assert property (
        hit(regWrEn, regAddr, ADDR_INT_CONTROL)
        |=> (state_reg.eventGate == $past(regWrData[IC_GATE])))
        else $error("event gate bit not written");

    AST_ROLE_WRITE: assert property (
        hit(regWrEn, regAddr, ADDR_INT_CONTROL)
        |=> (state_reg.pinIsOutput == $past(regWrData[IC_PINOUT])))
        else $error("pin role bit not written");

    AST_CTRL_HOLDS: assert property (
        !hit(regWrEn, regAddr, ADDR_INT_CONTROL)
        |=> $stable({state_reg.testForce, state_reg.eventGate, state_reg.pinIsOutput}))
        else $error("control bits changed without a write");

    AST_CTRL_READBACK: assert property (
        hit(regRdEn, regAddr, ADDR_INT_CONTROL)
        |=> (regRdData[IC_LOW_W-1:0]
             == $past({state_reg.testForce, state_reg.eventGate, state_reg.pinIsOutput})))
        else $error("control bits read back wrong");

    AST_EVENT_IRQ: assert property (
        (state_reg.eventGate && (|(flags & enables)))
        |-> irqPending)
        else $error("enabled event did not raise interrupt");

    AST_IRQ_CAUSE: assert property (
        irqPending
        |-> (state_reg.testForce || (state_reg.eventGate && (|(flags & enables)))))
        else $error("interrupt pending without a cause");

    AST_IRQ_CLEARS: assert property (
        (hit(regRdEn, regAddr, ADDR_EVENT_STATUS) && !(|eventPulse) && !state_reg.testForce
         && !hit(regWrEn, regAddr, ADDR_INT_CONTROL))
        |=> !irqPending)
        else $error("event read did not clear interrupt");

    AST_LINK_EVENT: assert property (
        ($past(reset_n) && $changed(linkUp))
        |=> flags[EV_LINK])
        else $error("link change not flagged");

    AST_ENERGY_EVENT: assert property (
        ($past(reset_n) && $changed(energyDetect))
        |=> flags[EV_ENERGY])
        else $error("energy change not flagged");

    AST_SPEED_EVENT: assert property (
        ($past(reset_n) && $changed(speed10))
        |=> flags[EV_SPEED])
        else $error("speed change not flagged");

    AST_DUPLEX_EVENT: assert property (
        ($past(reset_n) && $changed(fullDuplex))
        |=> flags[EV_DUPLEX])
        else $error("duplex change not flagged");

    AST_AN_EVENT: assert property (
        ($past(reset_n) && $rose(anComplete))
        |=> flags[EV_AN_DONE])
        else $error("auto-negotiation completion not flagged");

    AST_FC_EVENT: assert property (
        ($past(reset_n) && $rose(falseCarrierHalf))
        |=> flags[EV_FC_HALF])
        else $error("false carrier half-full not flagged");

    AST_RX_EVENT: assert property (
        ($past(reset_n) && $rose(rxErrorHalf))
        |=> flags[EV_RX_HALF])
        else $error("receive error half-full not flagged");
endmodule

/* pss_sm_model.sv */
// station manager model driving the register strobe port
`timescale 1ns/1ps
module pss_sm_model (
    input wire logic clk,
    output logic [4:0] regAddr,
    output logic regRdEn,
    output logic regWrEn,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid
);
    initial begin
        regAddr = 5'h00;
        regRdEn = 1'h0;
        regWrEn = 1'h0;
        regWrData = 16'h0000;
    end

    // one-cycle write strobe; data inverted after so stale data never looks valid
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'h1;
        @(posedge clk);
        regWrEn <= 1'h0;
        regWrData <= ~d;
        regAddr <= ~a;
    endtask

    // answer is registered on the taking edge and sampled 1 ns after it
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'h1;
        @(posedge clk);
        regRdEn <= 1'h0;
        regAddr <= ~a;
        #1;
        v = regRdValid;
        d = regRdData;
    endtask
endmodule

/* tb_phy_status_and_irq_control.sv */
// self-checking bench for the status word and interrupt control bank
`timescale 1ns/1ps
module tb_phy_status_and_irq_control import pss_pkg::*;;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [4:0] regAddr;
    logic regRdEn, regWrEn, regRdValid;
    logic [15:0] regWrData, regRdData;
    logic pageReceived = 1'h0;
    logic remoteFaultSeen = 1'h0;
    logic jabberDetect = 1'h0;
    logic loopbackOn = 1'h0;
    logic [6:0] evIn = 7'h00;
    logic padDrive = 1'h1;
    logic irqPinIn, irqPinOut, irqPinOe, powerDownReq;
    int fail_count = 0;
    int n_checks = 0;

    always #5 clk = ~clk;
    // pad level: our driver wins while enabled, else the outside world
    assign irqPinIn = irqPinOe ? irqPinOut : padDrive;

    pss_sm_model mgr (.clk(clk), .regAddr(regAddr), .regRdEn(regRdEn), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));

    pss_status_irq_regs uut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regRdEn(regRdEn), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid), .pageReceived(pageReceived),
        .remoteFaultSeen(remoteFaultSeen), .jabberDetect(jabberDetect),
        .anComplete(evIn[2]), .loopbackOn(loopbackOn), .fullDuplex(evIn[3]),
        .speed10(evIn[4]), .linkUp(evIn[5]), .energyDetect(evIn[6]),
        .falseCarrierHalf(evIn[1]), .rxErrorHalf(evIn[0]), .irqPinIn(irqPinIn),
        .irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .powerDownReq(powerDownReq));

    task automatic final_report();
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // invalid answer turns into unknowns so it never matches
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        mgr.rd(a, d, v);
        chk(v === 1'h1 ? d : 16'hXXXX, exp);
    endtask

    function automatic logic [15:0] stat(input logic pg, input logic irq, input logic rf);
        stat = {7'h00, pg, irq, rf, jabberDetect, evIn[2], loopbackOn, evIn[3], evIn[4], evIn[5]};
    endfunction

    task automatic pins(input int n, input logic [15:0] exp);
        repeat (n) @(posedge clk);
        #1;
        chk({13'h0000, powerDownReq, irqPinOe, irqPinOut}, exp);
    endtask

    task automatic t_reset();
        rdc(ADDR_INT_CONTROL, ZERO_WORD);
        rdc(ADDR_EVENT_STATUS, ZERO_WORD);
        rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h0, 1'h0));
        pins(1, 16'h0001);
    endtask

    task automatic t_levels();
        logic [5:0] pats [4] = '{6'h2A, 6'h15, 6'h3F, 6'h00};
        foreach (pats[k]) begin
            @(posedge clk);
            {jabberDetect, evIn[2], loopbackOn, evIn[3], evIn[4], evIn[5]} <= pats[k];
            @(posedge clk);
            rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h0, 1'h0));
            rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h0, 1'h0));
        end
    endtask

    task automatic t_sticky();
        @(posedge clk);
        pageReceived <= 1'h1;
        remoteFaultSeen <= 1'h1;
        @(posedge clk);
        pageReceived <= 1'h0;
        remoteFaultSeen <= 1'h0;
        rdc(ADDR_PHY_STATUS, stat(1'h1, 1'h0, 1'h1));
        rdc(ADDR_PHY_STATUS, stat(1'h1, 1'h0, 1'h1));
        rdc(ADDR_BASIC_STATUS, ZERO_WORD);
        rdc(ADDR_PHY_STATUS, stat(1'h1, 1'h0, 1'h0));
        rdc(ADDR_AN_EXPANSION, ZERO_WORD);
        rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h0, 1'h0));
    endtask

    task automatic t_control();
        mgr.wr(ADDR_INT_CONTROL, 16'hFFF8);
        rdc(ADDR_INT_CONTROL, ZERO_WORD);
        mgr.wr(ADDR_PHY_STATUS, 16'hFFFF);
        rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h0, 1'h0));
        mgr.wr(5'h1F, 16'hFFFF);
        rdc(5'h1F, ZERO_WORD);
        mgr.wr(ADDR_INT_CONTROL, 16'h0005);
        rdc(ADDR_INT_CONTROL, 16'h0005);
        rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h1, 1'h0));
        pins(2, 16'h0002);
        mgr.wr(ADDR_INT_CONTROL, 16'h0004);
        pins(2, 16'h0001);
        mgr.wr(ADDR_INT_CONTROL, 16'h0000);
        rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h0, 1'h0));
    endtask

    task automatic t_events();
        logic [15:0] d;
        logic v;
        mgr.rd(ADDR_EVENT_STATUS, d, v);
        mgr.wr(ADDR_INT_CONTROL, 16'h0003);
        for (int i = 0; i < NUM_EVENTS; i++) begin
            @(posedge clk);
            evIn[i] <= 1'h1;
            repeat (2) @(posedge clk);
            rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h0, 1'h0));
            rdc(ADDR_EVENT_STATUS, 16'h0001 << (FLAG_BASE + i));
        end
        @(posedge clk);
        evIn <= 7'h00;
        repeat (2) @(posedge clk);
        mgr.rd(ADDR_EVENT_STATUS, d, v);
        mgr.wr(ADDR_EVENT_STATUS, 16'h0020);
        @(posedge clk);
        evIn[5] <= 1'h1;
        repeat (3) @(posedge clk);
        rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h1, 1'h0));
        pins(1, 16'h0002);
        rdc(ADDR_EVENT_STATUS, 16'h2020);
        rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h0, 1'h0));
        mgr.wr(ADDR_INT_CONTROL, 16'h0001);
        @(posedge clk);
        evIn[5] <= 1'h0;
        repeat (3) @(posedge clk);
        rdc(ADDR_PHY_STATUS, stat(1'h0, 1'h0, 1'h0));
        pins(1, 16'h0003);
        rdc(ADDR_EVENT_STATUS, 16'h2020);
    endtask

    task automatic t_pin();
        mgr.wr(ADDR_INT_CONTROL, 16'h0000);
        @(posedge clk);
        padDrive <= 1'h0;
        pins(4, 16'h0005);
        @(posedge clk);
        padDrive <= 1'h1;
        pins(4, 16'h0001);
        mgr.wr(ADDR_INT_CONTROL, 16'h0001);
        padDrive <= 1'h0;
        pins(4, 16'h0003);
    endtask

    // whole run is under 200 cycles; this margin only catches a hang
    initial begin
        #200000;
        fail_count++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        t_reset();
        t_levels();
        t_sticky();
        t_control();
        t_events();
        t_pin();
        final_report();
    end
endmodule
